// file: logic/mvip_map.svh
`ifndef MVIP_MAP_SVH
`define MVIP_MAP_SVH
// vector table geometry
`define MVIP_NUM_VEC     10
`define MVIP_NUM_SRC     29
`define MVIP_NUM_EXT     8
`define MVIP_VEC_BASE    20'h00003
`define MVIP_VEC_STEP    20'h00008
// count of the leading vectors, from index 0, that may take the top level
`define MVIP_TOP_CAPABLE 2
// one saved level per possible nesting step
`define MVIP_STACK_DEPTH 3
// reset values
`define MVIP_ADDR_RST    20'h00000
`define MVIP_IDX_RST     4'h0
`endif

// file: logic/mvip_pkg.sv
`include "mvip_map.svh"
package mvip_pkg;
  // ordered so that a plain compare gives precedence
  typedef enum logic [1:0] {
    mvip_lvl_none = 2'b00,
    mvip_lvl_low  = 2'b01,
    mvip_lvl_high = 2'b10,
    mvip_lvl_top  = 2'b11
  } mvip_level_e;

  typedef enum logic [1:0] {
    mvip_sb_run   = 2'b00,
    mvip_sb_halt  = 2'b01,
    mvip_sb_hold  = 2'b10,
    mvip_sb_xhold = 2'b11
  } mvip_standby_e;

  // on-chip request levels, each held by its peripheral until serviced
  typedef struct packed {
    logic timer_zero_low_event;
    logic timer_zero_high_event;
    logic timer_one_low_event;
    logic timer_one_high_event;
    logic base_timer_a_event;
    logic base_timer_b_event;
    logic sync_serial_a_event;
    logic sync_async_serial_event;
    logic sync_serial_b_event;
    logic uart_a_rx_event;
    logic uart_b_rx_event;
    logic uart_a_tx_event;
    logic uart_b_tx_event;
    logic adc_event;
    logic timer_six_event;
    logic timer_seven_event;
    logic pwm_pair_b_event;
    logic port_zero_event;
    logic timer_four_event;
    logic timer_five_event;
    logic pwm_pair_a_event;
  } mvip_periph_s;

  typedef struct packed {
    logic        valid;
    logic [3:0]  index;
    logic [19:0] addr;
    mvip_level_e level;
  } mvip_grant_s;
endpackage

// file: logic/mvip_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module mvip_pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,   // system clock
  input  wire logic             rst_n,     // synchronised reset, active low
  input  wire logic [WIDTH-1:0] pin_raw,   // asynchronous pin levels
  output logic      [WIDTH-1:0] pin_clean  // settled levels
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // three-stage chain; s1 feeds only s2 to keep metastability contained
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a bit changes only once the late stages agree, filtering single-cycle glitches
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pin_clean <= '0;
    else
      for (int i = 0; i < WIDTH; i++)
        if (s2_r[i] == s3_r[i])
          pin_clean[i] <= s2_r[i];
  end
endmodule
`default_nettype wire

// file: logic/mvip_ctrl.sv
// Summary of operation
// - three nesting levels: highest above high, high above low
// - requests at or below the in-service level are refused
// - among pending vectors the highest level wins
// - equal levels resolve to the smallest vector address
// - 29 sources fold onto 10 vectors at 00003h, spaced eight bytes
// - only the first two vectors may be highest; others high or low
// - vectors three to ten are each shared by several sources
// - halt stops fetch and ends on reset or any request on an enabled vector
// - hold ends on reset, pins a,b,c,e,f at chosen level, or port-0 event
// - crystal hold also ends on a base timer event
`timescale 1ns/10ps
`default_nettype none
`include "mvip_map.svh"
module mvip_ctrl
  import mvip_pkg::*;
#(
  parameter int STACK_DEPTH = `MVIP_STACK_DEPTH
) (
  input  wire logic                     clk_sys,          // system clock
  input  wire logic                     rstn,             // reset pin, active low
  input  wire logic [`MVIP_NUM_EXT-1:0] ext_irq_pin,      // ext_irq_a..h pins, asynchronous
  input  wire logic [`MVIP_NUM_EXT-1:0] ext_active_high,  // 1: pin requests at high level
  input  wire mvip_periph_s             periph_req,       // on-chip request levels
  input  wire logic [`MVIP_NUM_VEC-1:0] vec_enable,       // per-vector enable
  input  wire logic [`MVIP_NUM_VEC-1:0] vec_level_up,     // 1: high (top for first two)
  input  wire logic                     irq_ack,          // cpu takes presented vector, pulse
  input  wire logic                     irq_ret,          // handler return, pulse
  input  wire logic                     standby_enter,    // enter standby, pulse
  input  wire mvip_standby_e            standby_mode,     // mode taken with standby_enter
  output logic                          irq_req,          // a vector is presented
  output logic [19:0]                   irq_vector_addr,  // presented vector address
  output mvip_level_e                   irq_level,        // level of presented vector
  output mvip_level_e                   service_level,    // level now in service
  output mvip_standby_e                 standby_state,    // current standby state
  output logic                          fetch_stop,       // instruction fetch halted
  output logic                          wake_pulse        // standby just ended
);
  localparam int NV  = `MVIP_NUM_VEC;
  localparam int SPW = $clog2(STACK_DEPTH + 1);

  logic [1:0]           rst_pipe_r;
  logic                 rst_n;
  logic [NV-1:0]        ext_lvl_ok;
  logic [7:0]           ext_clean;
  logic [NV-1:0]        vec_src;
  logic [NV-1:0]        vec_pend;
  logic [2*NV-1:0]      vec_lvls;
  mvip_level_e          cur_r;
  mvip_level_e          cur_nxt;
  mvip_level_e          stack_r [STACK_DEPTH];
  logic [SPW-1:0]       sp_r;
  logic [SPW-1:0]       sp_m1;
  mvip_grant_s          grant_r;
  mvip_grant_s          grant_nxt;
  logic                 ack_ok;
  logic                 ret_ok;
  logic                 hold_wake;
  logic                 wake_now;
  mvip_standby_e        sb_r;

  // reset pin released through two flops, asserted at once
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rst_pipe_r <= 2'h0;
    else
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
  end
  assign rst_n = rst_pipe_r[1];

  mvip_pin_sync #(
    .WIDTH (`MVIP_NUM_EXT)
  ) u_pin_sync (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .pin_raw   (ext_irq_pin),
    .pin_clean (ext_clean)
  );

  // a pin requests while it sits at its programmed level
  assign ext_lvl_ok = {2'h0, ext_clean ~^ ext_active_high};

  // source folding onto the ten vectors
  always_comb
  begin
    vec_src[0] = ext_lvl_ok[0];
    vec_src[1] = ext_lvl_ok[1];
    vec_src[2] = ext_lvl_ok[2] | periph_req.timer_zero_low_event | ext_lvl_ok[4];
    vec_src[3] = ext_lvl_ok[3] | ext_lvl_ok[5]
               | periph_req.base_timer_a_event | periph_req.base_timer_b_event;
    vec_src[4] = periph_req.timer_zero_high_event | ext_lvl_ok[6];
    vec_src[5] = periph_req.timer_one_low_event | periph_req.timer_one_high_event
               | ext_lvl_ok[7];
    vec_src[6] = periph_req.sync_serial_a_event | periph_req.uart_a_rx_event
               | periph_req.uart_b_rx_event;
    vec_src[7] = periph_req.sync_async_serial_event | periph_req.sync_serial_b_event
               | periph_req.uart_a_tx_event | periph_req.uart_b_tx_event;
    vec_src[8] = periph_req.adc_event | periph_req.timer_six_event
               | periph_req.timer_seven_event | periph_req.pwm_pair_b_event;
    vec_src[9] = periph_req.port_zero_event | periph_req.timer_four_event
               | periph_req.timer_five_event | periph_req.pwm_pair_a_event;
  end

  // level a vector carries; only the two pin vectors can reach the top
  function automatic mvip_level_e vec_level(input int idx, input logic en, input logic up);
    mvip_level_e l;
    l = mvip_lvl_low;
    if (!en)
      l = mvip_lvl_none;
    else if (up && idx < `MVIP_TOP_CAPABLE)
      l = mvip_lvl_top;
    else if (up)
      l = mvip_lvl_high;
    return l;
  endfunction

  // vector address from its index
  function automatic logic [19:0] vec_addr(input logic [3:0] idx);
    return `MVIP_VEC_BASE + (20'(idx) * `MVIP_VEC_STEP);
  endfunction

  // pick the best pending vector strictly above the floor level
  function automatic mvip_grant_s arbitrate(input logic [NV-1:0] pend,
                                            input logic [2*NV-1:0] lvls,
                                            input mvip_level_e floor);
    mvip_grant_s g;
    mvip_level_e l;
    g = '{valid: 1'b0, index: `MVIP_IDX_RST, addr: `MVIP_ADDR_RST, level: mvip_lvl_none};
    // downward scan with >= lets the smaller address take an equal level
    for (int i = NV - 1; i >= 0; i--)
    begin
      l = mvip_level_e'(lvls[2*i +: 2]);
      if (pend[i] && l > floor && l >= g.level)
      begin
        g.valid = 1'b1;
        g.index = 4'(i);
        g.level = l;
      end
    end
    g.addr = g.valid ? vec_addr(g.index) : `MVIP_ADDR_RST;
    return g;
  endfunction

  // per-vector pending and level
  always_comb
  begin
    for (int i = 0; i < NV; i++)
    begin
      vec_pend[i]       = vec_src[i] & vec_enable[i];
      vec_lvls[2*i +: 2] = vec_level(i, vec_enable[i], vec_level_up[i]);
    end
  end

  assign ack_ok = irq_ack & grant_r.valid;
  assign ret_ok = irq_ret & ~irq_ack & (sp_r != '0);
  assign sp_m1  = sp_r - SPW'(1);

  // service level next cycle; an ack in the same cycle as a return wins
  always_comb
  begin
    cur_nxt = cur_r;
    if (ack_ok)
      cur_nxt = grant_r.level;
    else if (ret_ok)
      cur_nxt = stack_r[sp_m1];
  end

  // in-service level and the stack of interrupted levels
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_r <= mvip_lvl_none;
      sp_r  <= '0;
      for (int i = 0; i < STACK_DEPTH; i++)
        stack_r[i] <= mvip_lvl_none;
    end
    else
    begin
      cur_r <= cur_nxt;
      if (ack_ok && sp_r < SPW'(STACK_DEPTH))
      begin
        stack_r[sp_r] <= cur_r;
        sp_r          <= sp_r + SPW'(1);
      end
      else if (ret_ok)
        sp_r <= sp_m1;
    end
  end

  // judged against the next service level so an accepted level never re-presents
  assign grant_nxt = arbitrate(vec_pend, vec_lvls, cur_nxt);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      grant_r <= '{valid: 1'b0, index: `MVIP_IDX_RST, addr: `MVIP_ADDR_RST,
                   level: mvip_lvl_none};
    else
      grant_r <= grant_nxt;
  end

  assign irq_req         = grant_r.valid;
  assign irq_vector_addr = grant_r.addr;
  assign irq_level       = grant_r.level;
  assign service_level   = cur_r;

  // hold exits: pins a,b,c,e,f at level or port 0; rstn itself clears all standby
  assign hold_wake = ext_lvl_ok[0] | ext_lvl_ok[1] | ext_lvl_ok[2] | ext_lvl_ok[4]
                   | ext_lvl_ok[5] | periph_req.port_zero_event;

  always_comb
  begin
    wake_now = 1'b0;
    unique case (sb_r)
      mvip_sb_run:   wake_now = 1'b0;
      mvip_sb_halt:  wake_now = |vec_pend;
      mvip_sb_hold:  wake_now = hold_wake;
      mvip_sb_xhold: wake_now = hold_wake | periph_req.base_timer_a_event
                              | periph_req.base_timer_b_event;
    endcase
  end

  // standby state; entry only from run, a wake condition present at entry
  // ends it on the next edge
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sb_r       <= mvip_sb_run;
      wake_pulse <= 1'b0;
    end
    else
    begin
      wake_pulse <= wake_now;
      if (wake_now)
        sb_r <= mvip_sb_run;
      else if (sb_r == mvip_sb_run && standby_enter)
        sb_r <= standby_mode;
    end
  end

  assign standby_state = sb_r;
  assign fetch_stop    = (sb_r != mvip_sb_run);
endmodule
`default_nettype wire

// file: sim/mvip_ctrl_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "mvip_map.svh"
module mvip_ctrl_assertions
  import mvip_pkg::*;
#(
  parameter int STACK_DEPTH = 3
) (
  input wire logic                     clk_sys,         // clock
  input wire logic                     rstn,            // reset pin
  input wire logic [`MVIP_NUM_EXT-1:0] ext_irq_pin,     // pins
  input wire logic [`MVIP_NUM_EXT-1:0] ext_active_high, // pin sense
  input wire mvip_periph_s             periph_req,      // sources
  input wire logic [`MVIP_NUM_VEC-1:0] vec_enable,      // enables
  input wire logic [`MVIP_NUM_VEC-1:0] vec_level_up,    // levels
  input wire logic                     irq_ack,         // accept
  input wire logic                     irq_ret,         // return
  input wire logic                     standby_enter,   // enter
  input wire mvip_standby_e            standby_mode,    // mode
  input wire logic                     irq_req,         // presented
  input wire logic [19:0]              irq_vector_addr, // address
  input wire mvip_level_e              irq_level,       // level
  input wire mvip_level_e              service_level,   // in service
  input wire mvip_standby_e            standby_state,   // state
  input wire logic                     fetch_stop,      // fetch off
  input wire logic                     wake_pulse       // woke
);
  // one domain, so the clock and reset are given once
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  chk_vec_table: assert property (irq_req |-> irq_vector_addr[2:0] == 3'h3
    && irq_vector_addr <= 20'h0004b) else $error("vector address off table");
  chk_idle_addr: assert property (!irq_req |-> irq_vector_addr == 20'h00000
    && irq_level == mvip_lvl_none) else $error("idle outputs not cleared");
  chk_above_svc: assert property (irq_req |-> irq_level > service_level)
    else $error("request not above service level");
  chk_top_only_ext: assert property (irq_req && irq_vector_addr > 20'h0000b
    |-> irq_level != mvip_lvl_top) else $error("shared vector at top level");
  chk_ack_level: assert property (irq_ack && irq_req
    |=> service_level == $past(irq_level)) else $error("accepted level not taken");
  chk_fetch_stop: assert property (fetch_stop == (standby_state != mvip_sb_run))
    else $error("fetch stop disagrees with state");
  // a request pending at entry shows for one cycle while halt ends
  chk_halt_no_req: assert property (standby_state == mvip_sb_halt
    && $past(standby_state) == mvip_sb_halt |-> !irq_req)
    else $error("halt kept with request shown");
  chk_enter_mode: assert property (standby_enter && standby_state == mvip_sb_run
    && standby_mode != mvip_sb_run |=> standby_state == $past(standby_mode))
    else $error("standby entry not taken");
  chk_wake_exit: assert property (standby_state != mvip_sb_run
    ##1 standby_state == mvip_sb_run |-> wake_pulse) else $error("no wake pulse");
  chk_hold_port0: assert property (standby_state inside {mvip_sb_hold, mvip_sb_xhold}
    && periph_req.port_zero_event |=> standby_state == mvip_sb_run)
    else $error("port event did not end hold");
  chk_xhold_timer: assert property (standby_state == mvip_sb_xhold
    && (periph_req.base_timer_a_event || periph_req.base_timer_b_event)
    |=> standby_state == mvip_sb_run) else $error("base timer did not end crystal hold");
endmodule
bind mvip_ctrl mvip_ctrl_assertions #(.STACK_DEPTH(STACK_DEPTH)) i_mvip_ctrl_assertions (
  .clk_sys, .rstn, .ext_irq_pin, .ext_active_high, .periph_req, .vec_enable,
  .vec_level_up, .irq_ack, .irq_ret, .standby_enter, .standby_mode, .irq_req,
  .irq_vector_addr, .irq_level, .service_level, .standby_state, .fetch_stop, .wake_pulse
);
`default_nettype wire

// file: sim/mvip_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module mvip_cpu_model (
  input  wire logic clk_sys, // clock
  input  wire logic irq_req, // vector shown
  input  wire logic ack_en,  // take vectors
  input  wire logic ret_en,  // finish a handler
  output logic      irq_ack, // accept pulse
  output logic      irq_ret  // return pulse
);
  int depth = 0;
  initial
  begin
    irq_ack = 1'b0;
    irq_ret = 1'b0;
  end
  // never ack twice running: the vector shown may still be the old one
  always @(posedge clk_sys)
  begin
    irq_ack <= ack_en && irq_req && !irq_ack;
    irq_ret <= ret_en && !ack_en && depth > 0 && !irq_ret; // returns pair with accepts
    depth <= depth + int'(ack_en && irq_req && !irq_ack) - int'(ret_en && !ack_en
      && depth > 0 && !irq_ret);
  end
endmodule
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import mvip_pkg::*;
  typedef struct packed {
    logic [20:0] src;
    logic [9:0]  en;
    logic [9:0]  up;
    logic [19:0] addr;
    logic [1:0]  lvl;
  } mvip_row_s;
  logic          clk_sys, rstn, irq_ack, irq_ret, ack_en, ret_en, standby_enter;
  logic          irq_req, fetch_stop, wake_pulse;
  logic [7:0]    ext_irq_pin;
  logic [7:0]    ext_active_high;
  mvip_periph_s  periph_req;
  logic [9:0]    vec_enable, vec_level_up;
  logic [19:0]   irq_vector_addr;
  mvip_level_e   irq_level, service_level;
  mvip_standby_e standby_mode, standby_state;
  int            fail_count = 0;
  int            tests_run = 0;
  int            i;
  mvip_row_s     rows [12];
  // pin sense starts high; one hold case switches pin b to active low
  mvip_ctrl i_mvip_ctrl (.clk_sys, .rstn, .ext_irq_pin, .ext_active_high,
    .periph_req, .vec_enable, .vec_level_up, .irq_ack, .irq_ret, .standby_enter,
    .standby_mode, .irq_req, .irq_vector_addr, .irq_level, .service_level,
    .standby_state, .fetch_stop, .wake_pulse);
  mvip_cpu_model i_mvip_cpu_model (.clk_sys, .irq_req, .ack_en, .ret_en, .irq_ack, .irq_ret);
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic enter(input mvip_standby_e m);
    standby_mode = m;
    standby_enter = 1'b1;
    step(1);
    standby_enter = 1'b0;
    step(1);
  endtask
  task automatic complete_run;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // the whole run is some 150 cycles; this leaves a wide margin
  initial
  begin
    #20000;
    fail_count++;
    complete_run();
  end
  initial
  begin
    {rstn, ack_en, ret_en, standby_enter, ext_irq_pin, vec_level_up} = '0;
    periph_req = '0;
    ext_active_high = 8'hff;
    standby_mode = mvip_sb_run;
    vec_enable = 10'h3ff;
    rows = '{'{21'h100000, 10'h3ff, 10'h000, 20'h00013, 2'h1},
      '{21'h008000, 10'h3ff, 10'h000, 20'h0001b, 2'h1},
      '{21'h020000, 10'h3ff, 10'h000, 20'h0002b, 2'h1},
      '{21'h000400, 10'h3ff, 10'h000, 20'h00033, 2'h1},
      '{21'h002000, 10'h3ff, 10'h000, 20'h0003b, 2'h1},
      '{21'h000010, 10'h3ff, 10'h000, 20'h00043, 2'h1},
      '{21'h000002, 10'h3ff, 10'h000, 20'h0004b, 2'h1},
      '{21'h080000, 10'h3ff, 10'h3ff, 20'h00023, 2'h2},
      '{21'h000088, 10'h3ff, 10'h000, 20'h00043, 2'h1},
      '{21'h000088, 10'h3ff, 10'h200, 20'h0004b, 2'h2},
      '{21'h000080, 10'h2ff, 10'h3ff, 20'h00000, 2'h0},
      '{21'h100001, 10'h3ff, 10'h3ff, 20'h00013, 2'h2}};
    step(2);
    cmp(20'(service_level), 20'(mvip_lvl_none));
    rstn = 1'b1;
    step(6);
    // plain presentation cases, no acceptance
    for (i = 0; i < 12; i++)
    begin
      periph_req = mvip_periph_s'(rows[i].src);
      vec_enable = rows[i].en;
      vec_level_up = rows[i].up;
      step(2);
      cmp(irq_vector_addr, rows[i].addr);
      cmp(20'(irq_level), 20'(rows[i].lvl));
      periph_req = '0;
      step(2);
    end
    // nesting: high, equal refused, top pin on top, then two returns
    vec_enable = 10'h3ff;
    ack_en = 1'b1;
    periph_req.adc_event = 1'b1;
    step(4);
    cmp(20'(service_level), 20'(mvip_lvl_high));
    periph_req = '0;
    periph_req.timer_five_event = 1'b1;
    step(4);
    cmp(20'(irq_req), 20'h0);
    ext_irq_pin = 8'h01;
    for (i = 0; i < 12 && service_level !== mvip_lvl_top; i++) step(1);
    cmp(20'(service_level), 20'(mvip_lvl_top));
    ext_irq_pin = 8'h00;
    ack_en = 1'b0;
    step(8);
    ret_en = 1'b1;
    step(1);
    ret_en = 1'b0;
    step(4);
    cmp(20'(service_level), 20'(mvip_lvl_high));
    cmp(20'(irq_req), 20'h0);
    ret_en = 1'b1;
    step(1);
    ret_en = 1'b0;
    step(4);
    cmp(irq_vector_addr, 20'h0004b);
    periph_req = '0;
    step(2);
    // halt ends on any enabled request
    enter(mvip_sb_halt);
    cmp(20'(fetch_stop), 20'h1);
    step(3);
    periph_req.adc_event = 1'b1;
    for (i = 0; i < 5 && standby_state !== mvip_sb_run; i++) step(1);
    cmp(20'(standby_state), 20'(mvip_sb_run));
    cmp(20'(wake_pulse), 20'h1);
    periph_req = '0;
    step(2);
    // hold ignores timer and converter, ends on port event
    enter(mvip_sb_hold);
    periph_req.base_timer_a_event = 1'b1;
    periph_req.adc_event = 1'b1;
    step(4);
    cmp(20'(standby_state), 20'(mvip_sb_hold));
    periph_req.port_zero_event = 1'b1;
    step(2);
    cmp(20'(standby_state), 20'(mvip_sb_run));
    periph_req = '0;
    step(2);
    enter(mvip_sb_xhold);
    periph_req.base_timer_b_event = 1'b1;
    step(2);
    cmp(20'(standby_state), 20'(mvip_sb_run));
    periph_req = '0;
    step(2);
    enter(mvip_sb_hold);
    ext_irq_pin = 8'h04;
    for (i = 0; i < 10 && standby_state !== mvip_sb_run; i++) step(1);
    cmp(20'(standby_state), 20'(mvip_sb_run));
    ext_irq_pin = 8'h00;
    step(8);
    // active-low pin b: idle high, hold ends when it is pulled low
    ext_irq_pin = 8'h02;
    step(6);
    ext_active_high = 8'hfd;
    enter(mvip_sb_hold);
    cmp(20'(standby_state), 20'(mvip_sb_hold));
    ext_irq_pin = 8'h00;
    for (i = 0; i < 10 && standby_state !== mvip_sb_run; i++) step(1);
    cmp(20'(standby_state), 20'(mvip_sb_run));
    cmp(irq_vector_addr, 20'h0000b);
    ext_active_high = 8'hff;
    step(2);
    // reset pin in mid-run also ends hold
    enter(mvip_sb_hold);
    rstn = 1'b0;
    step(1);
    cmp(20'(standby_state), 20'(mvip_sb_run));
    rstn = 1'b1;
    step(4);
    complete_run();
  end
endmodule
`default_nettype wire
